/* verilog/clock_source_pkg.sv */
// Purpose: constants, register map and state encoding of the clock source and prescaler
// Assumes: 125 MHz system clock; fuse inputs read 1 when programmed
// Notes:   source oscillators are modelled as enable pulses divided down from clk_i
package clock_source_pkg;

   // system clock
   localparam int          CLK_PERIOD_NS   = 8;

   // source select fuse codes
   localparam logic [3:0]  SRC_EXTERNAL    = 4'h0;
   localparam logic [3:0]  SRC_RC          = 4'h2;
   localparam logic [3:0]  SRC_LOW_FREQ    = 4'h3;

   // start-up time fuse codes
   localparam logic [1:0]  SUT_SHORT       = 2'h0;
   localparam logic [1:0]  SUT_FAST_RISE   = 2'h1;
   localparam logic [1:0]  SUT_SLOW_RISE   = 2'h2;

   // start-up clock counts
   localparam logic [15:0] WAKE_CK         = 16'h0006;
   localparam logic [15:0] RESET_CK        = 16'h000e;

   // oscillator models: dividers of clk_i
   localparam int          RC_DIV_DEFAULT  = 16;
   localparam int          LF_DIV_DEFAULT  = 977;
   localparam int          WDT_DIV_DEFAULT = 977;
   localparam int          WDT_PERIOD_NS   = WDT_DIV_DEFAULT * CLK_PERIOD_NS;

   // reset delays, in ns, and as watchdog ticks rounded up
   localparam int          T_4P1MS_NS      = 4100000;
   localparam int          T_65MS_NS       = 65000000;
   localparam int          T_4MS_NS        = 4000000;
   localparam int          T_64MS_NS       = 64000000;
   localparam int          WDT_4P1MS       = (T_4P1MS_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;
   localparam int          WDT_65MS        = (T_65MS_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;
   localparam int          WDT_4MS         = (T_4MS_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;
   localparam int          WDT_64MS        = (T_64MS_NS + WDT_PERIOD_NS - 1) / WDT_PERIOD_NS;

   // divider change procedure
   localparam logic [2:0]  UNLOCK_CK       = 3'h4;
   localparam int          UNLOCK_BIT      = 7;
   localparam logic [3:0]  DIV_SEL_DIV1    = 4'h0;
   localparam logic [3:0]  DIV_SEL_DIV8    = 4'h3;
   localparam logic [3:0]  DIV_SEL_MAX     = 4'h8;

   // register indices and byte addresses
   localparam logic [9:0]  DIVIDER_IDX     = 10'h061;
   localparam logic [9:0]  TRIM_IDX        = 10'h062;
   localparam logic [9:0]  STATUS_IDX      = 10'h063;
   localparam logic [11:0] DIVIDER_ADDR    = {DIVIDER_IDX, 2'b00};
   localparam logic [11:0] TRIM_ADDR       = {TRIM_IDX, 2'b00};
   localparam logic [11:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};

   // start-up sequencer, gray along reset -> run -> sleep -> wake
   typedef enum logic [2:0] {
      ST_RESET_CK = 3'b000,
      ST_RESET_MS = 3'b001,
      ST_RUN      = 3'b011,
      ST_SLEEP    = 3'b010,
      ST_WAKE     = 3'b110
   } boot_state_e;

   // low bits of the ripple counter that must be all ones for a divided tick
   function automatic logic [7:0] div_mask(input logic [3:0] sel);
      logic [8:0] m;
      m = (9'h001 << sel) - 9'h001;
      return m[7:0];
   endfunction

endpackage

/* verilog/clock_source_and_prescaler.sv */
// Purpose: system clock source selection, start-up delays and glitch-free prescaler
// Assumes: one clock clk_i; all slower clocks are one-cycle enables
// Notes:   registers on classic wishbone; fuses are captured while rst_i is high
`timescale 1ns/1ps
module clock_source_and_prescaler
  import clock_source_pkg::*;
#(
   parameter int RC_DIV        = RC_DIV_DEFAULT,
   parameter int LF_DIV        = LF_DIV_DEFAULT,
   parameter int WDT_DIV       = WDT_DIV_DEFAULT,
   parameter int WDT_4P1MS_CNT = WDT_4P1MS,
   parameter int WDT_65MS_CNT  = WDT_65MS,
   parameter int WDT_4MS_CNT   = WDT_4MS,
   parameter int WDT_64MS_CNT  = WDT_64MS
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [11:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // fuses and factory calibration
   input  wire logic [3:0]  source_select_fuses_i,
   input  wire logic [1:0]  startup_time_fuses_i,
   input  wire logic        initial_divide_by_eight_fuse_i,
   input  wire logic        clock_output_fuse_i,
   input  wire logic [7:0]  factory_calibration_i,
   // pins
   input  wire logic        external_clock_input_pin_i,
   output logic             clock_output_pin_o,
   output logic             clock_output_pin_oe_o,
   // power management
   input  wire logic        sleep_i,
   // clock domain enables and status
   output logic             clk_cpu_en_o,
   output logic             clk_io_en_o,
   output logic             clk_adc_en_o,
   output logic             clk_flash_en_o,
   output logic             wdt_tick_o,
   output logic             core_reset_o,
   output logic      [7:0]  rc_trim_o
);
   import clock_source_pkg::*;

   logic [15:0] rc_cnt_q;
   logic [15:0] lf_cnt_q;
   logic [15:0] wdt_cnt_q;
   logic        rc_tick;
   logic        lf_tick;
   logic        wdt_tick;
   logic        ext_meta_q;
   logic        ext_sync_q;
   logic        ext_prev_q;
   logic        ext_tick;
   logic [3:0]  src_sel_q;
   logic [1:0]  sut_q;
   logic        clock_output_fuse_q;
   logic        src_tick;
   logic        src_run;
   logic [7:0]  div_cnt_q;
   logic [7:0]  mask;
   logic [3:0]  sel_active_q;
   logic [3:0]  sel_pend_q;
   logic        chg_pend_q;
   logic        div_tick;
   logic        switch_now;
   logic        unlock_q;
   logic [2:0]  unlock_cnt_q;
   logic [7:0]  rc_trim_q;
   boot_state_e state_q;
   logic [15:0] wait_q;
   logic [15:0] ms_target;
   logic        bus_req;
   logic        bus_wr;
   logic        div_wr;
   logic        unlock_wr;
   logic        select_wr;
   logic [31:0] rd_data;

   // internal oscillator models: rc near 8 mhz, low-frequency near 128 khz
   assign rc_tick  = (rc_cnt_q == 16'(RC_DIV - 1));
   assign lf_tick  = (lf_cnt_q == 16'(LF_DIV - 1));
   assign wdt_tick = (wdt_cnt_q == 16'(WDT_DIV - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || rc_tick) begin
         rc_cnt_q <= 16'h0000;
      end else begin
         rc_cnt_q <= rc_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || lf_tick) begin
         lf_cnt_q <= 16'h0000;
      end else begin
         lf_cnt_q <= lf_cnt_q + 16'h0001;
      end
   end

   // watchdog oscillator stays independent of the selected source
   always_ff @(posedge clk_i) begin
      if (rst_i || wdt_tick) begin
         wdt_cnt_q <= 16'h0000;
      end else begin
         wdt_cnt_q <= wdt_cnt_q + 16'h0001;
      end
   end

   // external clock pin: two-stage synchroniser, then rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= external_clock_input_pin_i;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end
   assign ext_tick = ext_sync_q & ~ext_prev_q;

   // fuses are sampled while reset is held and frozen afterwards
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_sel_q <= source_select_fuses_i;
         sut_q     <= startup_time_fuses_i;
         clock_output_fuse_q   <= clock_output_fuse_i;
      end
   end

   // source selection; reserved codes give no clock at all
   always_comb begin
      case (src_sel_q)
         SRC_RC:       src_tick = rc_tick;
         SRC_LOW_FREQ: src_tick = lf_tick;
         SRC_EXTERNAL: src_tick = ext_tick;
         default:      src_tick = 1'b0;
      endcase
   end
   assign src_run = src_tick & ~sleep_i;

   // ripple divider on the undivided source; only the select is visible
   assign mask       = div_mask(sel_active_q);
   assign div_tick   = src_run && ((div_cnt_q & mask) == mask);
   assign switch_now = div_tick & chg_pend_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt_q <= 8'h00;
      end else if (switch_now) begin
         div_cnt_q <= 8'h00;
      end else if (src_run) begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // new select takes over only on a tick of the old rate, then counts a full new period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_active_q <= initial_divide_by_eight_fuse_i ? DIV_SEL_DIV8 : DIV_SEL_DIV1;
      end else if (switch_now) begin
         sel_active_q <= sel_pend_q;
      end
   end

   // wishbone decode
   assign bus_req   = cyc_i & stb_i & ~ack_o;
   assign bus_wr    = bus_req & we_i & sel_i[0];
   assign div_wr    = bus_wr & (adr_i == DIVIDER_ADDR);
   assign unlock_wr = div_wr & dat_i[UNLOCK_BIT] & (dat_i[6:0] == 7'h00);
   assign select_wr = div_wr & ~dat_i[UNLOCK_BIT];

   // unlock window counted in divided clock ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_q     <= 1'b0;
         unlock_cnt_q <= 3'h0;
      end else if (unlock_wr && !unlock_q) begin
         unlock_q     <= 1'b1;
         unlock_cnt_q <= UNLOCK_CK;
      end else if (unlock_q && select_wr) begin
         unlock_q     <= 1'b0;
      end else if (unlock_q && div_tick) begin
         if (unlock_cnt_q == 3'h1) begin
            unlock_q <= 1'b0;
         end
         unlock_cnt_q <= unlock_cnt_q - 3'h1;
      end
   end

   // select register: written only inside the window; reserved codes are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_pend_q <= initial_divide_by_eight_fuse_i ? DIV_SEL_DIV8 : DIV_SEL_DIV1;
         chg_pend_q <= 1'b0;
      end else if (unlock_q && select_wr && (dat_i[3:0] <= DIV_SEL_MAX)) begin
         sel_pend_q <= dat_i[3:0];
         chg_pend_q <= 1'b1;
      end else if (switch_now) begin
         chg_pend_q <= 1'b0;
      end
   end

   // rc trim register, loaded from the factory byte on reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rc_trim_q <= factory_calibration_i;
      end else if (bus_wr && (adr_i == TRIM_ADDR)) begin
         rc_trim_q <= dat_i[7:0];
      end
   end

   // extra reset delay per source and start-up code; reserved code takes the longest
   always_comb begin
      case (sut_q)
         SUT_SHORT:     ms_target = 16'h0000;
         SUT_FAST_RISE: ms_target = (src_sel_q == SRC_LOW_FREQ) ? 16'(WDT_4MS_CNT) : 16'(WDT_4P1MS_CNT);
         SUT_SLOW_RISE: ms_target = (src_sel_q == SRC_LOW_FREQ) ? 16'(WDT_64MS_CNT) : 16'(WDT_65MS_CNT);
         default:       ms_target = (src_sel_q == SRC_LOW_FREQ) ? 16'(WDT_64MS_CNT) : 16'(WDT_65MS_CNT);
      endcase
   end

   // start-up sequencer: source clocks first, then watchdog-timed delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_RESET_CK;
         wait_q  <= 16'h0000;
      end else begin
         case (state_q)
            ST_RESET_CK: begin
               if (src_tick) begin
                  if (wait_q == RESET_CK - 16'h0001) begin
                     state_q <= (ms_target == 16'h0000) ? ST_RUN : ST_RESET_MS;
                     wait_q  <= 16'h0000;
                  end else begin
                     wait_q <= wait_q + 16'h0001;
                  end
               end
            end
            ST_RESET_MS: begin
               if (wdt_tick) begin
                  if (wait_q == ms_target - 16'h0001) begin
                     state_q <= ST_RUN;
                     wait_q  <= 16'h0000;
                  end else begin
                     wait_q <= wait_q + 16'h0001;
                  end
               end
            end
            ST_RUN: begin
               if (sleep_i) begin
                  state_q <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (!sleep_i) begin
                  state_q <= ST_WAKE;
                  wait_q  <= 16'h0000;
               end
            end
            ST_WAKE: begin
               if (src_tick) begin
                  if (wait_q == WAKE_CK - 16'h0001) begin
                     state_q <= ST_RUN;
                     wait_q  <= 16'h0000;
                  end else begin
                     wait_q <= wait_q + 16'h0001;
                  end
               end
            end
            default: begin
               state_q <= ST_RESET_CK;
               wait_q  <= 16'h0000;
            end
         endcase
      end
   end

   // gated domain enables, all from the same divided tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_cpu_en_o   <= 1'b0;
         clk_io_en_o    <= 1'b0;
         clk_adc_en_o   <= 1'b0;
         clk_flash_en_o <= 1'b0;
         core_reset_o   <= 1'b1;
      end else begin
         clk_cpu_en_o   <= div_tick & (state_q == ST_RUN);
         clk_io_en_o    <= div_tick & (state_q == ST_RUN);
         clk_adc_en_o   <= div_tick & (state_q == ST_RUN);
         clk_flash_en_o <= div_tick & (state_q == ST_RUN);
         core_reset_o   <= (state_q == ST_RESET_CK) || (state_q == ST_RESET_MS);
      end
   end

   // clock output pin: one high cycle per divided period, runs through the reset time-out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_output_pin_o    <= 1'b0;
         clock_output_pin_oe_o <= clock_output_fuse_i;
      end else begin
         clock_output_pin_o    <= clock_output_fuse_q & div_tick;
         clock_output_pin_oe_o <= clock_output_fuse_q;
      end
   end

   // watchdog tick and trim value out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_tick_o <= 1'b0;
         rc_trim_o  <= 8'h00;
      end else begin
         wdt_tick_o <= wdt_tick;
         rc_trim_o  <= rc_trim_q;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (adr_i)
         DIVIDER_ADDR: rd_data[7:0] = {unlock_q, 3'h0, sel_pend_q};
         TRIM_ADDR:    rd_data[7:0] = rc_trim_q;
         STATUS_ADDR:  rd_data[7:0] = {chg_pend_q, (state_q == ST_RUN), sut_q, src_sel_q};
         default:      rd_data = 32'h0000_0000;
      endcase
   end

   // single-wait-state acknowledge for every address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            dat_o <= rd_data;
         end
      end
   end

endmodule

/* testbench/ext_clock_source.sv */
// Purpose: model of the external clock source on the clock input pin
// Assumes: fixed period, unrelated in phase to the system clock
// Notes:   the period never steps, so no reset is needed around a change
`timescale 1ns/1ps
module ext_clock_source #(
   parameter int HALF_NS = 24
) (
   // clock pin
   output logic pin_o
);
   // steady square wave, same period every cycle
   initial begin
      pin_o = 1'b0;
      #3;
      forever begin
         #(HALF_NS) pin_o = ~pin_o;
      end
   end
endmodule

/* testbench/clock_source_asserts.sv */
// Purpose: concurrent checks on the clock source and prescaler ports
// Assumes: single clock, synchronous active-high reset
// Notes:   bound into every instance of the top module
`timescale 1ns/1ps
module clock_source_asserts #(
   parameter int WDT_DIV = 977
) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // bus
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // fuses and outputs
   input wire logic        clock_output_fuse_i,
   input wire logic [7:0]  factory_calibration_i,
   input wire logic        clock_output_pin_o,
   input wire logic        clock_output_pin_oe_o,
   input wire logic        clk_cpu_en_o,
   input wire logic        clk_io_en_o,
   input wire logic        clk_adc_en_o,
   input wire logic        clk_flash_en_o,
   input wire logic        wdt_tick_o,
   input wire logic        core_reset_o,
   input wire logic [7:0]  rc_trim_o
);
   logic [15:0] gap_q;
   logic        seen_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // cycles since the last watchdog tick
   always_ff @(posedge clk_i) begin
      if (rst_i || wdt_tick_o) gap_q <= 16'h0000;
      else gap_q <= gap_q + 16'h0001;
   end
   // a first tick has been seen since reset
   always_ff @(posedge clk_i) begin
      if (rst_i) seen_q <= 1'b0;
      else if (wdt_tick_o) seen_q <= 1'b1;
   end
   ack_after_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
   ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   read_upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000) else $error("upper read bits set");
   trim_loaded_a: assert property ($fell(rst_i) |-> ##2 rc_trim_o == factory_calibration_i)
      else $error("trim not loaded");
   domains_equal_a: assert property ((clk_io_en_o == clk_cpu_en_o) && (clk_adc_en_o == clk_cpu_en_o)
      && (clk_flash_en_o == clk_cpu_en_o))
      else $error("domains divided unequally");
   enable_pulse_a: assert property (clk_cpu_en_o |=> !clk_cpu_en_o) else $error("enable too long");
   pin_follows_a: assert property (clk_cpu_en_o && clock_output_pin_oe_o |-> clock_output_pin_o)
      else $error("pin misses divided clock");
   pin_idle_a: assert property (!clock_output_pin_oe_o |-> !clock_output_pin_o) else $error("pin driven");
   oe_fuse_a: assert property (clock_output_pin_oe_o == clock_output_fuse_i) else $error("oe differs");
   wdt_period_a: assert property (wdt_tick_o && seen_q |-> gap_q == 16'(WDT_DIV - 1))
      else $error("watchdog period wrong");
   cover property (ack_o);
   cover property ($fell(core_reset_o));
   cover property (clock_output_pin_o && clock_output_pin_oe_o);
endmodule
bind clock_source_and_prescaler clock_source_asserts #(.WDT_DIV(WDT_DIV)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
   .clock_output_fuse_i(clock_output_fuse_i), .factory_calibration_i(factory_calibration_i),
   .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe_o(clock_output_pin_oe_o),
   .clk_cpu_en_o(clk_cpu_en_o), .clk_io_en_o(clk_io_en_o), .clk_adc_en_o(clk_adc_en_o),
   .clk_flash_en_o(clk_flash_en_o), .wdt_tick_o(wdt_tick_o), .core_reset_o(core_reset_o), .rc_trim_o(rc_trim_o));

/* testbench/clock_source_and_prescaler_test.sv */
// Purpose: self-checking bench for clock source selection and prescaler
// Assumes: shortened oscillator and millisecond counts
// Notes:   random trim and calibration values from a fixed-seed xorshift
`timescale 1ns/1ps
module clock_source_and_prescaler_test;
   import clock_source_pkg::*;
   localparam int RCD = 4;
   localparam int LFD = 8;
   localparam int EXD = 6;
   logic        clk, rst, cyc, stb, we, div8, clock_output_fuse, ext, pin, oe, sleep;
   logic        en_cpu, en_io, en_adc, en_flash, wdt, core_rst, ack;
   logic [11:0] adr;
   logic [3:0]  sel, src;
   logic [1:0]  startup_time_fuses;
   logic [31:0] wdat, rdat, r, v;
   logic [7:0]  cal, trim;
   logic [31:0] seed = 32'h00002e32;
   int          err_count = 0;
   int          checks = 0;
   int          n, k, e;
   clock_source_and_prescaler #(.RC_DIV(RCD), .LF_DIV(LFD), .WDT_DIV(8), .WDT_4P1MS_CNT(3), .WDT_65MS_CNT(3),
      .WDT_4MS_CNT(3), .WDT_64MS_CNT(3)) uut (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .source_select_fuses_i(src), .startup_time_fuses_i(startup_time_fuses),
      .initial_divide_by_eight_fuse_i(div8), .clock_output_fuse_i(clock_output_fuse), .factory_calibration_i(cal),
      .external_clock_input_pin_i(ext), .clock_output_pin_o(pin), .clock_output_pin_oe_o(oe), .sleep_i(sleep),
      .clk_cpu_en_o(en_cpu), .clk_io_en_o(en_io), .clk_adc_en_o(en_adc), .clk_flash_en_o(en_flash),
      .wdt_tick_o(wdt), .core_reset_o(core_rst), .rc_trim_o(trim));
   ext_clock_source #(.HALF_NS(EXD * 4)) src_model (.pin_o(ext));
   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   initial begin
      #600000;
      err_count++;
      print_verdict();
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // start-up length window: 14 source ticks plus millisecond ticks
   function automatic logic boot_ok(int cnt, int d, int ms);
      return cnt >= 14 * d + ms * 8 - 8 && cnt <= 14 * d + ms * 8 + 2 * d + 16;
   endfunction
   task automatic print_verdict();
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
      int t;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 100);
      if (ack !== 1'b1) err_count++; // a missing acknowledge counts as a mismatch
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic d8, input logic co);
      @(posedge clk);
      rst <= 1'b1; src <= s; startup_time_fuses <= u; div8 <= d8; clock_output_fuse <= co; cal <= 8'(rnd());
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (core_rst !== 1'b0 && n < 3000);
   endtask
   // cycles between two divided clock enables
   task automatic per();
      k = 0;
      while (en_cpu !== 1'b1 && k < 5000) begin @(negedge clk); k++; end
      @(negedge clk);
      n = 1;
      while (en_cpu !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
   endtask
   initial begin
      rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 12'h000; sel = 4'h0; wdat = 32'h0;
      src = SRC_RC; startup_time_fuses = SUT_SHORT; div8 = 1'b1; clock_output_fuse = 1'b1; cal = 8'h00; sleep = 1'b0;
      // internal rc, shipped divide by eight
      boot(SRC_RC, SUT_SHORT, 1'b1, 1'b1);
      chk(32'h1, 32'(boot_ok(n, RCD, 0)));
      bus(1'b0, DIVIDER_ADDR, 32'h0, 4'hf, r);
      chk(32'(DIV_SEL_DIV8), r);
      bus(1'b0, TRIM_ADDR, 32'h0, 4'hf, r);
      chk({24'h0, cal}, r);
      bus(1'b0, STATUS_ADDR, 32'h0, 4'hf, r);
      chk({24'h0, 2'b01, SUT_SHORT, SRC_RC}, r);
      per();
      chk(RCD * 8, n);
      // every select code, reserved ones first
      e = 3;
      for (int i = 15; i >= 0; i--) begin
         // unlock and select back to back, well inside the four-tick window; only a select write closes it early
         bus(1'b1, DIVIDER_ADDR, 32'h80, 4'h1, r);
         bus(1'b1, DIVIDER_ADDR, i, 4'h1, r);
         if (i <= 8) e = i;
         bus(1'b0, DIVIDER_ADDR, 32'h0, 4'hf, r);
         chk(e, r);
         per();
         per();
         chk(RCD << e, n);
      end
      // unlock set, then lapses after four ticks
      bus(1'b1, DIVIDER_ADDR, 32'h80, 4'h1, r);
      bus(1'b0, DIVIDER_ADDR, 32'h0, 4'hf, r);
      chk(32'h80, r);
      repeat (40) @(posedge clk);
      bus(1'b1, DIVIDER_ADDR, 32'h5, 4'h1, r);
      bus(1'b0, DIVIDER_ADDR, 32'h0, 4'hf, r);
      chk(32'h0, r);
      // unlock with other bits set does nothing
      bus(1'b1, DIVIDER_ADDR, 32'h81, 4'h1, r);
      bus(1'b1, DIVIDER_ADDR, 32'h5, 4'h1, r);
      bus(1'b0, DIVIDER_ADDR, 32'h0, 4'hf, r);
      chk(32'h0, r);
      // trim write, masked write, unmapped place
      v = rnd();
      bus(1'b1, TRIM_ADDR, v, 4'h1, r);
      bus(1'b1, TRIM_ADDR, ~v, 4'he, r);
      bus(1'b0, TRIM_ADDR, 32'h0, 4'hf, r);
      chk({24'h0, v[7:0]}, r);
      bus(1'b1, 12'h200, v, 4'hf, r);
      bus(1'b0, 12'h200, 32'h0, 4'hf, r);
      chk(32'h0, r);
      // sleep stops the clocks, wake waits six source ticks
      @(posedge clk);
      sleep <= 1'b1;
      // an enable launched at this very edge still stands in the next half cycle
      @(negedge clk);
      k = 0;
      repeat (30) begin @(negedge clk); if (en_cpu !== 1'b0) k++; end
      chk(32'h0, k);
      @(posedge clk);
      sleep <= 1'b0;
      n = 0;
      do begin @(negedge clk); n++; end while (en_cpu !== 1'b1 && n < 500);
      chk(32'h1, 32'(n >= 6 * RCD && n <= 7 * RCD + 6));
      // 128 khz source, fast-rise delay, pin off
      boot(SRC_LOW_FREQ, SUT_FAST_RISE, 1'b0, 1'b0);
      chk(32'h1, 32'(boot_ok(n, LFD, 3)));
      chk(32'h0, 32'(oe));
      per();
      chk(LFD, n);
      // reserved start-up code takes the slow delay
      boot(SRC_RC, 2'h3, 1'b1, 1'b1);
      chk(32'h1, 32'(boot_ok(n, RCD, 3)));
      // reserved source code gives no clock, so the core stays in reset
      boot(4'h1, SUT_SHORT, 1'b0, 1'b0);
      chk(32'h1, 32'(core_rst));
      // external clock, slow-rise delay
      boot(SRC_EXTERNAL, SUT_SLOW_RISE, 1'b0, 1'b1);
      chk(32'h1, 32'(boot_ok(n, EXD, 3)));
      per();
      chk(EXD, n);
      print_verdict();
   end
endmodule
